// [src/cam_alarm_monitor.sv]
// Converter alarm monitor top: sticky event status, mask, summary alarm,
// status pin drive and link enable control.
// Assumes event inputs are synchronous to ref_clk and a strobe register port.
//
// Overview of operation
// - One sticky status bit per source; set when its event occurs.
// - Status bits hold after the event; cleared only by writing one.
// - An alarm reaches the summary only when its mask bit is clear.
// - With pin select on alarm, status pin is high while alarm stands.
// - Channel A and B clocks compared; any divided-cycle mismatch flags upset.
// - Leaving global power-down may set the upset flag; host clears it.
// - Upset lane FIFO pointers set that lane's error flag.
// - Link enable rising from zero to one resets the lane FIFO logic.
// - Link outside data transmission raises an alarm.
// - SYSREF realignment of internal clocks raises an alarm.
// - Lane FIFO read or write error raises an alarm.
// - Link enable low holds link in reset, serializers down, clocks gated.
`timescale 1ns/10ps
module cam_alarm_monitor
(
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic [31:0]                        reg_rdata,
   input  wire logic                          cpll_unlocked,
   input  wire logic                          spll_unlocked,
   input  wire logic                          link_in_data,
   input  wire logic                          sysref_realign,
   input  wire logic                          chan_a_clk,
   input  wire logic                          chan_b_clk,
   input  wire logic [cam_pkg::NUM_LANES-1:0] lane_fifo_err,
   input  wire logic                          powerdown_pin,
   output logic                               status_out_pin,
   output logic                               summary_alarm,
   output logic                               link_reset,
   output logic                               serializer_pd,
   output logic                               link_clk_en,
   output logic                               lane_fifo_reset
);
   import cam_pkg::*;

   logic [NUM_BITS-1:0] event_status_bits_q;
   logic [NUM_BITS-1:0] event_status_bits_d;
   logic [NUM_BITS-1:0] event_mask_bits_q;
   logic [NUM_BITS-1:0] set_vec;
   logic [NUM_BITS-1:0] clr_vec;
   logic [3:0]          ctrl_q;
   logic                pin_sel_q;
   logic                link_enable;
   logic                link_enable_prev_q;
   logic                gpd_prev_q;
   logic                gpd_exit;
   logic                fifo_rst_q;
   logic                wake_q;
   logic                chan_both_on;
   logic [31:0]         rdata_q;
   cam_event_if         ev ();

   // Read-back helper for the status and mask registers: widen value to a word.
   function automatic logic [31:0] widen(input logic [NUM_BITS-1:0] v);
      widen = {19'h00000, v};
   endfunction : widen

   assign link_enable  = ctrl_q[BIT_LINK_EN];
   assign chan_both_on = ~ctrl_q[BIT_PD_A] & ~ctrl_q[BIT_PD_B];

   // Clock comparison runs only with the link up and both channels powered.
   assign ev.clk_a      = chan_a_clk;
   assign ev.clk_b      = chan_b_clk;
   assign ev.compare_en = link_enable & chan_both_on;

   cam_clk_compare u_cmp
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ev      (ev)
   );

   // Global power-down is pin or control bit; its falling edge is an exit.
   assign gpd_exit = gpd_prev_q & ~(powerdown_pin | ctrl_q[BIT_GLOBAL_PD]);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         gpd_prev_q <= 1'b0;
      else
         gpd_prev_q <= powerdown_pin | ctrl_q[BIT_GLOBAL_PD];
   end

   // Exit from power-down may leave a spurious upset; it is recorded.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         wake_q <= 1'b0;
      else
         wake_q <= gpd_exit;
   end

   // Event sources gathered into one set vector.
   always_comb
   begin
      set_vec = '0;
      set_vec[BIT_CPLL_UNLOCK] = cpll_unlocked;
      set_vec[BIT_SPLL_UNLOCK] = spll_unlocked;
      set_vec[BIT_LINK_IDLE]   = ~link_in_data;
      set_vec[BIT_REALIGN]     = sysref_realign;
      set_vec[BIT_CLK_UPSET]   = ev.upset_pulse | wake_q;
      set_vec[BIT_LANE_FIFO +: NUM_LANES] = lane_fifo_err
         & {NUM_LANES{link_enable & ~fifo_rst_q}};
   end

   // Write-one-to-clear mask from the host.
   always_comb
   begin
      clr_vec = '0;
      if (reg_wr && reg_addr == ADDR_EVENT_STATUS)
         clr_vec = reg_wdata[NUM_BITS-1:0];
   end

   // Sticky update; a new event wins over a clear in the same cycle.
   assign event_status_bits_d = (event_status_bits_q & ~clr_vec) | set_vec;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         event_status_bits_q <= RST_STATUS;
      else
         event_status_bits_q <= event_status_bits_d;
   end

   AST_STICKY_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      (event_status_bits_q[BIT_CPLL_UNLOCK] && !clr_vec[BIT_CPLL_UNLOCK])
      |=> event_status_bits_q[BIT_CPLL_UNLOCK])
      else $error("Status bit dropped without a write of one.");

   AST_SET_CPLL: assert property (@(posedge ref_clk) disable iff (rst)
      cpll_unlocked |=> event_status_bits_q[BIT_CPLL_UNLOCK])
      else $error("Loss of lock did not set its status bit.");

   AST_SET_LINK: assert property (@(posedge ref_clk) disable iff (rst)
      !link_in_data |=> event_status_bits_q[BIT_LINK_IDLE])
      else $error("Link outside data state did not raise alarm.");

   AST_SET_SYSREF: assert property (@(posedge ref_clk) disable iff (rst)
      sysref_realign |=> event_status_bits_q[BIT_REALIGN])
      else $error("Realignment did not raise alarm.");

   AST_CLEAR_WORKS: assert property (@(posedge ref_clk) disable iff (rst)
      (clr_vec[BIT_SPLL_UNLOCK] && !spll_unlocked)
      |=> !event_status_bits_q[BIT_SPLL_UNLOCK])
      else $error("Write of one did not clear status bit.");

   AST_UPSET_SETS: assert property (@(posedge ref_clk) disable iff (rst)
      ev.upset_pulse |=> event_status_bits_q[BIT_CLK_UPSET])
      else $error("Clock upset did not set the flag.");

   AST_WAKE_UPSET: assert property (@(posedge ref_clk) disable iff (rst)
      gpd_exit |=> ##1 event_status_bits_q[BIT_CLK_UPSET])
      else $error("Power-down exit did not flag upset.");

   // Mask register and control registers written by the host.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         event_mask_bits_q <= RST_MASK;
      else if (reg_wr && reg_addr == ADDR_EVENT_MASK)
         event_mask_bits_q <= reg_wdata[NUM_BITS-1:0];
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ctrl_q <= RST_CTRL;
      else if (reg_wr && reg_addr == ADDR_LINK_CTRL)
         ctrl_q <= reg_wdata[3:0];
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         pin_sel_q <= RST_PINSEL;
      else if (reg_wr && reg_addr == ADDR_PIN_SEL)
         pin_sel_q <= reg_wdata[0];
   end

   // Link enable edge tracking for the FIFO reset pulse.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         link_enable_prev_q <= 1'b0;
      else
         link_enable_prev_q <= link_enable;
   end

   // Rising link enable gives one cycle of lane FIFO reset.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         fifo_rst_q <= 1'b0;
      else
         fifo_rst_q <= link_enable & ~link_enable_prev_q;
   end

   assign lane_fifo_reset = fifo_rst_q | ~link_enable;

   AST_FIFO_RESET: assert property (@(posedge ref_clk) disable iff (rst)
      ($rose(link_enable)) |=> lane_fifo_reset)
      else $error("Link enable rise did not reset lane FIFO.");

   // Link held in reset, powered down and clock gated while disabled.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         link_reset    <= 1'b1;
         serializer_pd <= 1'b1;
         link_clk_en   <= 1'b0;
      end
      else
      begin
         link_reset    <= ~link_enable;
         serializer_pd <= ~link_enable;
         link_clk_en   <= link_enable;
      end
   end

   AST_LINK_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      !link_enable |=> (link_reset && serializer_pd && !link_clk_en))
      else $error("Disabled link not held in reset.");

   // Summary alarm from unmasked sticky bits, every cycle.
   assign summary_alarm  = |(event_status_bits_q & ~event_mask_bits_q);
   assign status_out_pin = pin_sel_q & summary_alarm;

   AST_MASKED_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
      ((event_status_bits_q & ~event_mask_bits_q) == '0) |-> !summary_alarm)
      else $error("Masked alarm reached the summary.");

   AST_PIN_ALARM: assert property (@(posedge ref_clk) disable iff (rst)
      (pin_sel_q && summary_alarm) |-> status_out_pin)
      else $error("Status pin low while alarm stands.");

   // The pin stays low while it is not selected for the alarm function.
   AST_PIN_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
      !pin_sel_q |-> !status_out_pin)
      else $error("Status pin high while not selected.");

   // Any unmasked sticky bit must show on the summary in the same cycle.
   AST_SUMMARY_UP: assert property (@(posedge ref_clk) disable iff (rst)
      ((event_status_bits_q & ~event_mask_bits_q) != '0) |-> summary_alarm)
      else $error("Unmasked alarm missing from the summary.");

   // A mask write lands in the next cycle with the written low bits.
   AST_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_wr && reg_addr == ADDR_EVENT_MASK)
      |=> (event_mask_bits_q == $past(reg_wdata[NUM_BITS-1:0])))
      else $error("Mask write did not land.");

   // Every bit that is set and not cleared survives to the next cycle.
   AST_STICKY_ALL: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1 |=> ((event_status_bits_q & $past(event_status_bits_q & ~clr_vec))
                == $past(event_status_bits_q & ~clr_vec)))
      else $error("Sticky status bit dropped on its own.");

   // A new event beats a clear of the same bit in the same cycle.
   AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (rst)
      (clr_vec[BIT_REALIGN] && sysref_realign)
      |=> event_status_bits_q[BIT_REALIGN])
      else $error("Clear won over a new realignment event.");

   AST_SET_SPLL: assert property (@(posedge ref_clk) disable iff (rst)
      spll_unlocked |=> event_status_bits_q[BIT_SPLL_UNLOCK])
      else $error("Second loss of lock did not set its status bit.");

   // A lane error with the link running and no FIFO reset pulse sets that lane's flag.
   AST_SET_LANE: assert property (@(posedge ref_clk) disable iff (rst)
      (lane_fifo_err[0] && link_enable && !fifo_rst_q)
      |=> event_status_bits_q[BIT_LANE_FIFO])
      else $error("Lane error did not set its flag.");

   // No upset pulse can come from a comparator that is switched off.
   AST_CMP_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      !ev.compare_en |=> !ev.upset_pulse)
      else $error("Upset flagged with the compare disabled.");

   // The lane FIFO is held in reset for as long as the link is off.
   AST_FIFO_HELD: assert property (@(posedge ref_clk) disable iff (rst)
      !link_enable |-> lane_fifo_reset)
      else $error("Lane FIFO not held while link is off.");

   // An enabled link leaves reset and gets its clock one cycle later.
   AST_LINK_ON: assert property (@(posedge ref_clk) disable iff (rst)
      link_enable |=> (!link_reset && !serializer_pd && link_clk_en))
      else $error("Enabled link still held off.");

   // A status read returns the sticky bits in the following cycle.
   AST_READ_STATUS: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_rd && reg_addr == ADDR_EVENT_STATUS)
      |=> (reg_rdata == widen($past(event_status_bits_q))))
      else $error("Status read returned a wrong word.");

   // Registered read data, one cycle after the read strobe; zero otherwise.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rdata_q <= 32'h00000000;
      else if (reg_rd)
      begin
         case (reg_addr)
            ADDR_EVENT_STATUS: rdata_q <= widen(event_status_bits_q);
            ADDR_EVENT_MASK:   rdata_q <= widen(event_mask_bits_q);
            ADDR_LINK_CTRL:    rdata_q <= {28'h0000000, ctrl_q};
            ADDR_PIN_SEL:      rdata_q <= {31'h00000000, pin_sel_q};
            ADDR_SUMMARY:      rdata_q <= {31'h00000000, summary_alarm};
            default:           rdata_q <= 32'h00000000;
         endcase
      end
      else
         rdata_q <= 32'h00000000;
   end

   assign reg_rdata = rdata_q;

endmodule : cam_alarm_monitor

// [src/cam_pkg.sv]
// Package for the converter alarm monitor: register map, field positions,
// reset values and timing constants.
// Assumes a host that reaches registers over a plain strobe port.
package cam_pkg;

   // Register offsets, as byte addresses.
   localparam logic [7:0] ADDR_EVENT_STATUS = 8'h00;
   localparam logic [7:0] ADDR_EVENT_MASK   = 8'h04;
   localparam logic [7:0] ADDR_LINK_CTRL    = 8'h08;
   localparam logic [7:0] ADDR_PIN_SEL      = 8'h0c;
   localparam logic [7:0] ADDR_SUMMARY      = 8'h10;

   // Number of serializer lanes and of status bits.
   localparam int NUM_LANES = 8;
   localparam int NUM_BITS  = 13;

   // Status bit positions.
   localparam int BIT_CPLL_UNLOCK = 0;
   localparam int BIT_SPLL_UNLOCK = 1;
   localparam int BIT_LINK_IDLE   = 2;
   localparam int BIT_REALIGN     = 3;
   localparam int BIT_CLK_UPSET   = 4;
   localparam int BIT_LANE_FIFO   = 5;

   // Link control field positions.
   localparam int BIT_LINK_EN = 0;
   localparam int BIT_PD_A    = 1;
   localparam int BIT_PD_B    = 2;
   localparam int BIT_GLOBAL_PD = 3;

   // Reset values.
   localparam logic [NUM_BITS-1:0] RST_STATUS = 13'h0000;
   localparam logic [NUM_BITS-1:0] RST_MASK   = 13'h1fff;
   localparam logic [3:0]          RST_CTRL   = 4'h0;
   localparam logic                RST_PINSEL = 1'b0;

   // Clock compare runs on device clock divided by this ratio.
   localparam int CMP_DIV = 2;

endpackage : cam_pkg

// [src/cam_event_if.sv]
// Interface carrying raw event levels from the top to the compare leaf.
// Assumes both ends share ref_clk.
`timescale 1ns/10ps
interface cam_event_if;
   logic clk_a;
   logic clk_b;
   logic compare_en;
   logic upset_pulse;
   modport top
   (
      output clk_a,
      output clk_b,
      output compare_en,
      input  upset_pulse
   );
   modport cmp
   (
      input  clk_a,
      input  clk_b,
      input  compare_en,
      output upset_pulse
   );
endinterface : cam_event_if

// [src/cam_clk_compare.sv]
// Channel clock comparator: flags any mismatch sampled on the divided rate.
// Assumes the channel clock phases arrive synchronous to ref_clk.
`timescale 1ns/10ps
module cam_clk_compare
(
   input wire logic ref_clk,
   input wire logic rst,
   cam_event_if.cmp ev
);
   import cam_pkg::*;

   logic div_q;

   // Divider gives one enable pulse every second device clock.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         div_q <= 1'b0;
      else
         div_q <= ~div_q;
   end

   // Mismatch in any single divided cycle produces one upset pulse.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ev.upset_pulse <= 1'b0;
      else
         ev.upset_pulse <= div_q & ev.compare_en & (ev.clk_a != ev.clk_b);
   end

   AST_CMP_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
      (div_q && ev.compare_en && ev.clk_a != ev.clk_b) |=> ev.upset_pulse)
      else $error("Clock mismatch did not raise upset pulse.");

endmodule : cam_clk_compare

// [tb/tb_cam_alarm_monitor.sv]
// Self-checking bench for the converter alarm monitor top.
// Assumes cam_pkg, the event interface and the design modules come first.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb_cam_alarm_monitor;
   import cam_pkg::*;
   logic                 ref_clk = 1'h0;
   logic                 rst = 1'h1;
   logic [7:0]           reg_addr = 8'h00;
   logic [31:0]          reg_wdata = 32'h0;
   logic [31:0]          reg_rdata;
   logic                 reg_wr = 1'h0;
   logic                 reg_rd = 1'h0;
   logic                 cpll = 1'h0;
   logic                 spll = 1'h0;
   logic                 in_data = 1'h1;
   logic                 realign = 1'h0;
   logic                 clk_a = 1'h0;
   logic                 clk_b = 1'h0;
   logic                 skw = 1'h0;
   logic                 pd_pin = 1'h0;
   logic [NUM_LANES-1:0] lane_err = '0;
   logic                 pin, summ, lrst, spd, lclk, frst;
   int                   n_mismatch = 0;
   int                   n_checks = 0;
   int                   cycles = 0;

   cam_alarm_monitor cam_alarm_monitor_inst
   (
      .ref_clk         (ref_clk),
      .rst             (rst),
      .reg_addr        (reg_addr),
      .reg_wdata       (reg_wdata),
      .reg_wr          (reg_wr),
      .reg_rd          (reg_rd),
      .reg_rdata       (reg_rdata),
      .cpll_unlocked   (cpll),
      .spll_unlocked   (spll),
      .link_in_data    (in_data),
      .sysref_realign  (realign),
      .chan_a_clk      (clk_a),
      .chan_b_clk      (clk_b),
      .lane_fifo_err   (lane_err),
      .powerdown_pin   (pd_pin),
      .status_out_pin  (pin),
      .summary_alarm   (summ),
      .link_reset      (lrst),
      .serializer_pd   (spd),
      .link_clk_en     (lclk),
      .lane_fifo_reset (frst)
   );

   // Free-running 100 MHz clock.
   always #5 ref_clk = ~ref_clk;

   // Channel phases toggle together; skw forces a mismatch.
   always @(posedge ref_clk)
   begin
      clk_b <= ~clk_b;
      clk_a <= ~clk_b ^ skw;
   end

   // Cuts a hung run short.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   // Prints the counts and the verdict, then stops.
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   // One-cycle register write.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask : wr

   // One-cycle register read, compared in the following cycle.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rd

   // Raises one event source for a single cycle.
   task automatic fire(input int k);
      @(posedge ref_clk);
      case (k)
         0: cpll <= 1'h1;
         1: spll <= 1'h1;
         2: in_data <= 1'h0;
         3: realign <= 1'h1;
         default: lane_err[k-5] <= 1'h1;
      endcase
      @(posedge ref_clk);
      cpll <= 1'h0;
      spll <= 1'h0;
      in_data <= 1'h1;
      realign <= 1'h0;
      lane_err <= '0;
      repeat (2) @(posedge ref_clk);
   endtask : fire

   // Mismatches the channels for one divided-clock period.
   task automatic skew;
      @(posedge ref_clk);
      skw <= 1'h1;
      repeat (2) @(posedge ref_clk);
      skw <= 1'h0;
      repeat (5) @(posedge ref_clk);
      #1;
   endtask : skew

   // Main sequence of tests.
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'h0;
      rd(ADDR_EVENT_STATUS, 32'h0);
      rd(ADDR_EVENT_MASK, 32'h1fff);
      rd(ADDR_LINK_CTRL, 32'h0);
      rd(ADDR_PIN_SEL, 32'h0);
      rd(8'h14, 32'h0);
      `CHK({lrst, spd, lclk, frst}, 4'hd)
      fire(5);
      rd(ADDR_EVENT_STATUS, 32'h0);
      $display("test reset done");
      wr(ADDR_LINK_CTRL, 32'h1);
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK({lrst, spd, lclk, frst}, 4'h2)
      for (int k = 0; k < NUM_BITS; k++)
      begin
         if (k == BIT_CLK_UPSET)
            continue;
         fire(k);
         wr(ADDR_EVENT_STATUS, 32'h0);
         rd(ADDR_EVENT_STATUS, 32'h1 << k);
         `CHK(summ, 1'h0)
         wr(ADDR_EVENT_STATUS, 32'h1 << k);
         rd(ADDR_EVENT_STATUS, 32'h0);
      end
      $display("test sticky done");
      fire(BIT_REALIGN);
      wr(ADDR_EVENT_MASK, 32'h1ff7);
      #1;
      `CHK({summ, pin}, 2'h2)
      rd(ADDR_SUMMARY, 32'h1);
      wr(ADDR_PIN_SEL, 32'h1);
      #1;
      `CHK(pin, 1'h1)
      wr(ADDR_EVENT_MASK, 32'h1fff);
      #1;
      `CHK({summ, pin}, 2'h0)
      wr(ADDR_EVENT_MASK, 32'h0);
      wr(ADDR_EVENT_STATUS, 32'h8);
      #1;
      `CHK({summ, pin}, 2'h0)
      $display("test mask done");
      wr(ADDR_LINK_CTRL, 32'h3);
      skew();
      rd(ADDR_EVENT_STATUS, 32'h0);
      wr(ADDR_LINK_CTRL, 32'h0);
      wr(ADDR_LINK_CTRL, 32'h1);
      wr(ADDR_EVENT_STATUS, 32'h10);
      rd(ADDR_EVENT_STATUS, 32'h0);
      skew();
      `CHK({summ, pin}, 2'h3)
      rd(ADDR_EVENT_STATUS, 32'h10);
      wr(ADDR_EVENT_STATUS, 32'h10);
      $display("test upset done");
      wr(ADDR_LINK_CTRL, 32'h9);
      wr(ADDR_LINK_CTRL, 32'h1);
      repeat (3) @(posedge ref_clk);
      rd(ADDR_EVENT_STATUS, 32'h10);
      wr(ADDR_EVENT_STATUS, 32'h10);
      rd(ADDR_EVENT_STATUS, 32'h0);
      @(posedge ref_clk);
      pd_pin <= 1'h1;
      @(posedge ref_clk);
      pd_pin <= 1'h0;
      repeat (4) @(posedge ref_clk);
      rd(ADDR_EVENT_STATUS, 32'h10);
      $display("test powerdown done");
      close_out();
   end
endmodule : tb_cam_alarm_monitor
